// File: src/sensor_i2c_pkg.sv
// Shared constants and types of the sensor two-wire slave port
package sensor_i2c_pkg;
	localparam int REG_W = 24;
	localparam int CTRL_W = 14;
	localparam int STATUS_W = 12;
	localparam int CMD_W = 16;
	localparam int CUR_W = 9;
	// Register addresses on the serial bus
	localparam logic [7:0] REG_DATA = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h01;
	// Data register field positions
	localparam int CUR_LSB = 0;
	localparam int SYNC_BIT = 9;
	localparam int LATCH_BIT = 10;
	localparam int LIVE_BIT = 11;
	// Control register field positions
	localparam int RANGE_LSB = 0;
	localparam int LEVEL_LSB = 2;
	localparam int AVG_LSB = 6;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;
	// Command word carried to the core domain
	localparam int CMD_READ_CLR = 14;
	localparam int CMD_FAULT_RST = 15;
	// Averaging shift limit, 2**8 = 256 samples
	localparam logic [3:0] AVG_MAX_SHIFT = 4'h8;
	// Bit counter values within a byte slot, and the last byte index of a word
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [1:0] LAST_BYTE = 2'h2;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DEV = 3'b011,
		ST_REG = 3'b010,
		ST_WDATA = 3'b110,
		ST_RDATA = 3'b111
	} link_state_type;
endpackage : sensor_i2c_pkg

// File: src/word_xfer_if.sv
// Word handshake carrier between two clock domains
`timescale 1ns/1ps
interface word_xfer_if #(parameter int WIDTH = 16);
	logic send;
	logic busy;
	logic [WIDTH-1:0] data;
	logic valid;
	logic [WIDTH-1:0] word;
	modport src (output send, output data, input busy);
	modport dst (input valid, input word);
	modport sync (input send, input data, output busy, output valid, output word);
endinterface : word_xfer_if

// File: src/bit_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module bit_sync #(parameter int WIDTH = 1) (
	// Destination clock
	input wire logic clk_i,
	// Asynchronous level in, synchronised level out
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta;

	// No reset: the chain also synchronises the reset itself
	always_ff @(posedge clk_i) begin
		meta <= d_i;
		q_o <= meta;
	end
endmodule : bit_sync

// File: src/word_sync.sv
// Toggle handshake that carries a word across clock domains
`timescale 1ns/1ps
module word_sync #(parameter int WIDTH = 16) (
	// Source domain
	input wire logic src_clk_i,
	input wire logic src_reset_n_i,
	// Destination domain
	input wire logic dst_clk_i,
	input wire logic dst_reset_n_i,
	// Carrier
	word_xfer_if.sync x
);
	logic req_t;
	logic ack_t;
	logic req_q;
	logic ack_q;
	logic [WIDTH-1:0] hold;

	bit_sync #(.WIDTH(1)) u_req (.clk_i(dst_clk_i), .d_i(req_t), .q_o(req_q));
	bit_sync #(.WIDTH(1)) u_ack (.clk_i(src_clk_i), .d_i(ack_t), .q_o(ack_q));

	// Hold stays still while the request is open, so the far side reads it safely
	assign x.busy = req_t != ack_q;

	always_ff @(posedge src_clk_i) begin
		if (!src_reset_n_i) begin
			req_t <= 1'b0;
			hold <= '0;
		end else if (x.send && !x.busy) begin
			hold <= x.data;
			req_t <= ~req_t;
		end
	end

	always_ff @(posedge dst_clk_i) begin
		if (!dst_reset_n_i) begin
			ack_t <= 1'b0;
			x.valid <= 1'b0;
			x.word <= '0;
		end else begin
			x.valid <= req_q != ack_t;
			if (req_q != ack_t) begin
				x.word <= hold;
				ack_t <= req_q;
			end
		end
	end
endmodule : word_sync

// File: src/sensor_i2c_slave_port.sv
// Two-wire slave port of the current sensor with its result and control registers
`timescale 1ns/1ps

// How it works
// R1: SDA falling while SCL high opens a transaction.
// R2: SDA rising while SCL high closes the transaction.
// R3: First byte after start is seven address bits, direction, then acknowledge.
// R4: Each data byte is eight bits plus one acknowledge; bytes may repeat.
// R5: SDA changes only while SCL is low, except start and stop.
// R6: Any start or stop restarts the byte sequence at once.
// R7: Direction bit low means write, high means read.
// R8: Own address matched means SDA driven low on the ninth clock.
// R9: Every written byte, register address included, is acknowledged.
// R10: Master releases SDA before each ninth clock.
// R11: Write is address with direction zero, register address, then data.
// R12: Registers are 24 bits, moved as three bytes.
// R13: Without stop, next three bytes go to register address plus one.
// R14: Master ends a write with a stop.
// R15: A trailing partial group of bytes is dropped.
// R16: Two strap inputs pick one of sixteen bus addresses.
// R17: Data word holds 9-bit current, live, latched and new-data flags.
// R18: Control holds range, fault level and averaging.
// R19: Results are averaged over up to 256 samples.
// R20: Freeze input holds the reported current steady.
// R21: Master makes SCL; the port drives SDA only open drain.
// R22: Read is register address write, repeated start, then three bytes.
// R23: Read continues at address plus one; master ends with no acknowledge.
// R24: New-data flag sets on a result, clears when data register is read.
// R25: Latched fault clears by writing bit 10 once the fault has gone.
// R26: SCL and SDA are synchronised and their edges found from samples.
// R27: A data read snapshots all three bytes at the first byte.
module sensor_i2c_slave_port
#(
	parameter logic [2:0] OWN_ADDR_MSB = 3'h4
) (
	// Core clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Link sampling clock
	input wire logic link_clk_i,
	// Serial bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Address straps, four voltage levels each
	input wire logic [1:0] addr_strap_low_i,
	input wire logic [1:0] addr_strap_high_i,
	// Converter and comparator
	input wire logic [sensor_i2c_pkg::CUR_W-1:0] adc_sample_i,
	input wire logic adc_valid_i,
	input wire logic over_current_i,
	input wire logic freeze_i,
	// Control outputs to the analog front end
	output logic [1:0] range_sel_o,
	output logic [3:0] fault_level_o,
	output logic [7:0] avg_sel_o
);
	import sensor_i2c_pkg::*;

	function automatic logic [7:0] word_byte(input logic [REG_W-1:0] w, input logic [1:0] idx);
		case (idx)
			2'h0: word_byte = w[23:16];
			2'h1: word_byte = w[15:8];
			default: word_byte = w[7:0];
		endcase
	endfunction : word_byte

	word_xfer_if #(.WIDTH(STATUS_W)) status_if ();
	word_xfer_if #(.WIDTH(CMD_W)) cmd_if ();

	logic link_rst_n;
	logic [1:0] pin_q;
	logic [3:0] strap_q;
	logic freeze_q;
	logic scl;
	logic sda;
	logic scl_d;
	logic sda_d;
	logic start_seen;
	logic stop_seen;
	logic scl_rise;
	logic scl_fall;
	logic [6:0] own_addr;
	link_state_type state;
	logic [3:0] bit_cnt;
	logic [7:0] rx_shift;
	logic [7:0] tx_shift;
	logic [1:0] byte_idx;
	logic [7:0] reg_addr;
	logic [15:0] wr_word;
	logic [REG_W-1:0] tx_word;
	logic [REG_W-1:0] next_word;
	logic [REG_W-1:0] commit_word;
	logic [7:0] commit_addr;
	logic commit_stb;
	logic rd_clr_stb;
	logic [CTRL_W-1:0] ctrl_shadow;
	logic [STATUS_W-1:0] status_copy;
	logic cmd_send;
	logic [CMD_W-1:0] cmd_data;
	logic fault_wr;
	logic ctrl_wr;

	// Link domain sees the core reset only through a synchroniser
	bit_sync #(.WIDTH(1)) u_link_rst (.clk_i(link_clk_i), .d_i(reset_n_i), .q_o(link_rst_n));
	bit_sync #(.WIDTH(2)) u_pins (.clk_i(link_clk_i), .d_i({scl_i, sda_i}), .q_o(pin_q)); // R26
	bit_sync #(.WIDTH(4)) u_strap (
		.clk_i(link_clk_i),
		.d_i({addr_strap_high_i, addr_strap_low_i}),
		.q_o(strap_q)
	);
	bit_sync #(.WIDTH(1)) u_freeze (.clk_i(clk_i), .d_i(freeze_i), .q_o(freeze_q));

	word_sync #(.WIDTH(STATUS_W)) u_status_sync (
		.src_clk_i(clk_i),
		.src_reset_n_i(reset_n_i),
		.dst_clk_i(link_clk_i),
		.dst_reset_n_i(link_rst_n),
		.x(status_if.sync)
	);
	word_sync #(.WIDTH(CMD_W)) u_cmd_sync (
		.src_clk_i(link_clk_i),
		.src_reset_n_i(link_rst_n),
		.dst_clk_i(clk_i),
		.dst_reset_n_i(reset_n_i),
		.x(cmd_if.sync)
	);

	assign scl = pin_q[1];
	assign sda = pin_q[0];
	assign start_seen = scl && scl_d && sda_d && !sda; // R1
	assign stop_seen = scl && scl_d && !sda_d && sda; // R2
	// R5: bits are taken only on SCL edges, so SDA moves while low are harmless
	assign scl_rise = scl && !scl_d;
	assign scl_fall = !scl && scl_d;

	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl; // R26
			sda_d <= sda;
		end
	end

	// Straps are caught while the link reset is held and then stay put
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n) begin
			own_addr <= {OWN_ADDR_MSB, strap_q}; // R16
		end
	end

	// Word offered on a read of the addressed register
	always_comb begin
		case (reg_addr)
			REG_DATA: next_word = {{(REG_W - STATUS_W){1'b0}}, status_copy};
			REG_CTRL: next_word = {{(REG_W - CTRL_W){1'b0}}, ctrl_shadow};
			default: next_word = '0;
		endcase
	end

	// Protocol engine; sda_o stays low, only the enable moves (open drain)
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			rx_shift <= 8'h00;
			tx_shift <= 8'h00;
			byte_idx <= 2'h0;
			reg_addr <= 8'h00;
			wr_word <= 16'h0000;
			tx_word <= '0;
			commit_word <= '0;
			commit_addr <= 8'h00;
			commit_stb <= 1'b0;
			rd_clr_stb <= 1'b0;
			sda_o <= 1'b0;
			sda_oe_o <= 1'b0;
		end else begin
			commit_stb <= 1'b0;
			rd_clr_stb <= 1'b0;
			sda_o <= 1'b0; // R21
			if (start_seen) begin
				// Repeated start keeps the register address for a combined read
				state <= ST_START; // R6
				bit_cnt <= 4'h0;
				byte_idx <= 2'h0;
				sda_oe_o <= 1'b0;
			end else if (stop_seen) begin
				state <= ST_IDLE; // R6
				bit_cnt <= 4'h0;
				byte_idx <= 2'h0;
				sda_oe_o <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: begin
						sda_oe_o <= 1'b0;
					end
					ST_START: begin
						// The falling SCL that ends the start is not a bit
						if (scl_fall) begin
							state <= ST_DEV; // R3
						end
					end
					ST_DEV, ST_REG, ST_WDATA, ST_RDATA: begin
						if (scl_rise && bit_cnt != BIT_ACK) begin
							rx_shift <= {rx_shift[6:0], sda}; // R4
						end
						if (scl_rise && bit_cnt == BIT_ACK && state == ST_RDATA && sda) begin
							// No acknowledge: the master is done reading
							state <= ST_IDLE; // R23
						end
						if (scl_fall) begin
							if (bit_cnt == BIT_LAST) begin
								bit_cnt <= BIT_ACK;
								case (state)
									ST_DEV: begin
										if (rx_shift[7:1] == own_addr) begin
											sda_oe_o <= 1'b1; // R8
											state <= rx_shift[0] ? ST_RDATA : ST_REG; // R7
										end else begin
											sda_oe_o <= 1'b0;
											state <= ST_IDLE;
										end
									end
									ST_REG: begin
										reg_addr <= rx_shift; // R11
										sda_oe_o <= 1'b1; // R9
										state <= ST_WDATA;
									end
									ST_WDATA: begin
										sda_oe_o <= 1'b1; // R9
										if (byte_idx == LAST_BYTE) begin
											commit_word <= {wr_word, rx_shift}; // R12
											commit_addr <= reg_addr;
											commit_stb <= 1'b1;
											reg_addr <= reg_addr + 8'h01; // R13
											byte_idx <= 2'h0;
										end else begin
											// R15: a group not completed never commits
											wr_word <= {wr_word[7:0], rx_shift};
											byte_idx <= byte_idx + 2'h1;
										end
									end
									default: begin
										sda_oe_o <= 1'b0; // R10
									end
								endcase
							end else if (bit_cnt == BIT_ACK) begin
								bit_cnt <= 4'h0;
								sda_oe_o <= 1'b0;
								if (state == ST_RDATA) begin
									if (byte_idx == 2'h0) begin
										tx_word <= next_word; // R27
										tx_shift <= word_byte(next_word, 2'h0);
										sda_oe_o <= !next_word[23];
										rd_clr_stb <= reg_addr == REG_DATA; // R24
									end else begin
										tx_shift <= word_byte(tx_word, byte_idx);
										sda_oe_o <= !tx_word[5'd23 - {byte_idx, 3'b000}]; // R22
									end
									if (byte_idx == LAST_BYTE) begin
										byte_idx <= 2'h0;
										reg_addr <= reg_addr + 8'h01; // R23
									end else begin
										byte_idx <= byte_idx + 2'h1;
									end
								end
							end else begin
								bit_cnt <= bit_cnt + 4'h1;
								if (state == ST_RDATA) begin
									tx_shift <= {tx_shift[6:0], 1'b0};
									sda_oe_o <= !tx_shift[6];
								end
							end
						end
					end
					default: begin
						state <= ST_IDLE;
						sda_oe_o <= 1'b0;
					end
				endcase
			end
		end
	end

	// Control shadow and command word toward the core
	assign fault_wr = commit_stb && commit_addr == REG_DATA && commit_word[LATCH_BIT]; // R25
	assign ctrl_wr = commit_stb && commit_addr == REG_CTRL; // R18
	assign cmd_if.send = cmd_send;
	assign cmd_if.data = cmd_data;

	// Events closer together than one crossing would be lost; bytes are far slower
	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n) begin
			ctrl_shadow <= CTRL_RESET;
			cmd_send <= 1'b0;
			cmd_data <= {2'b00, CTRL_RESET};
		end else begin
			if (ctrl_wr) begin
				ctrl_shadow <= commit_word[CTRL_W-1:0];
			end
			cmd_send <= fault_wr || ctrl_wr || rd_clr_stb;
			cmd_data <= {fault_wr, rd_clr_stb,
				ctrl_wr ? commit_word[CTRL_W-1:0] : ctrl_shadow};
		end
	end

	always_ff @(posedge link_clk_i) begin
		if (!link_rst_n) begin
			status_copy <= '0;
		end else if (status_if.valid) begin
			status_copy <= status_if.word;
		end
	end

	// Core domain: control, averaging and flags
	logic [3:0] avg_shift;
	logic [16:0] acc;
	logic [8:0] sample_cnt;
	logic [16:0] sum;
	logic [16:0] avg_full;
	logic avg_done;
	logic [CUR_W-1:0] current;
	logic new_data;
	logic fault_latched;
	logic fault_live;
	logic fault_rst;
	logic read_clr;

	assign fault_rst = cmd_if.valid && cmd_if.word[CMD_FAULT_RST];
	assign read_clr = cmd_if.valid && cmd_if.word[CMD_READ_CLR];

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			range_sel_o <= CTRL_RESET[RANGE_LSB +: 2];
			fault_level_o <= CTRL_RESET[LEVEL_LSB +: 4];
			avg_sel_o <= CTRL_RESET[AVG_LSB +: 8];
		end else if (cmd_if.valid) begin
			range_sel_o <= cmd_if.word[RANGE_LSB +: 2]; // R18
			fault_level_o <= cmd_if.word[LEVEL_LSB +: 4];
			avg_sel_o <= cmd_if.word[AVG_LSB +: 8];
		end
	end

	// Power-of-two window keeps the divide a shift; settings above 8 mean 256
	assign avg_shift = (avg_sel_o > {4'h0, AVG_MAX_SHIFT}) ? AVG_MAX_SHIFT : avg_sel_o[3:0];
	assign sum = acc + {8'h00, adc_sample_i};
	assign avg_full = sum >> avg_shift;
	assign avg_done = adc_valid_i && ({8'h00, sample_cnt} + 17'h00001) >= (17'h00001 << avg_shift);

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			acc <= 17'h00000;
			sample_cnt <= 9'h000;
		end else if (avg_done) begin
			acc <= 17'h00000; // R19
			sample_cnt <= 9'h000;
		end else if (adc_valid_i) begin
			acc <= sum;
			sample_cnt <= sample_cnt + 9'h001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			current <= '0;
			new_data <= 1'b0;
		end else if (avg_done && !freeze_q) begin
			current <= avg_full[CUR_W-1:0]; // R20
			new_data <= 1'b1; // R24
		end else if (read_clr) begin
			new_data <= 1'b0;
		end
	end

	// A fault still present wins over the reset request
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			fault_live <= 1'b0;
			fault_latched <= 1'b0;
		end else begin
			fault_live <= over_current_i;
			if (over_current_i) begin
				fault_latched <= 1'b1;
			end else if (fault_rst) begin
				fault_latched <= 1'b0; // R25
			end
		end
	end

	// Status is resent whenever the crossing is free
	assign status_if.send = !status_if.busy;
	assign status_if.data = {fault_live, fault_latched, new_data, current}; // R17
endmodule : sensor_i2c_slave_port

// File: bench/sensor_i2c_slave_port_asserts.sv
// Concurrent checks on the pins of the sensor two-wire slave port
`timescale 1ns/1ps
module sensor_i2c_slave_port_asserts (
	// Clocks and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic link_clk_i,
	// Serial pins
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	// Control outputs
	input wire logic [1:0] range_sel_o,
	input wire logic [3:0] fault_level_o,
	input wire logic [7:0] avg_sel_o
);
	logic [5:0] idle_cnt;
	// Core cycles of idle bus, saturating
	always_ff @(posedge clk_i) begin
		if (!reset_n_i || !(scl_i && sda_i)) begin
			idle_cnt <= 6'h00;
		end else if (idle_cnt != 6'h3F) begin
			idle_cnt <= idle_cnt + 6'h01;
		end
	end
	sequence start_seq;
		scl_i && sda_i ##1 scl_i && !sda_i;
	endsequence
	sequence stop_seq;
		scl_i && !sda_i ##1 scl_i && sda_i;
	endsequence
	// Slack covers the two-flop delay on an unaligned clock fall
	sequence fell_lately;
		$past(scl_i, 3) || $past(scl_i, 4) || $past(scl_i, 5) || $past(scl_i, 6);
	endsequence
	a_open_drain_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		sda_o == 1'b0) else $error("data output not held low");
	a_reset_silent: assert property (@(posedge link_clk_i)
		!reset_n_i [*4] |-> !sda_oe_o) else $error("data driven during reset");
	a_stable_scl_high: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		scl_i [*6] |-> $stable(sda_oe_o)) else $error("data moved while clock high");
	a_oe_follows_fall: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		$changed(sda_oe_o) |-> !scl_i ##0 fell_lately) else $error("drive not timed to clock fall");
	a_stop_releases: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		stop_seq |=> !sda_oe_o [*8]) else $error("data driven after stop");
	a_start_releases: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
		start_seq |=> !sda_oe_o [*8]) else $error("data driven after start");
	a_ctrl_reset_zero: assert property (@(posedge clk_i)
		!reset_n_i |=> range_sel_o == 2'h0 && fault_level_o == 4'h0 && avg_sel_o == 8'h00)
		else $error("control not cleared by reset");
	a_ctrl_quiet_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		idle_cnt == 6'h3F |-> $stable({range_sel_o, fault_level_o, avg_sel_o}))
		else $error("control changed on idle bus");
endmodule : sensor_i2c_slave_port_asserts

bind sensor_i2c_slave_port sensor_i2c_slave_port_asserts i_chk (
	.clk_i(clk_i),
	.reset_n_i(reset_n_i),
	.link_clk_i(link_clk_i),
	.scl_i(scl_i),
	.sda_i(sda_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.range_sel_o(range_sel_o),
	.fault_level_o(fault_level_o),
	.avg_sel_o(avg_sel_o)
);

// File: bench/i2c_master_model.sv
// Behavioural two-wire bus master for the sensor port
`timescale 1ns/1ps
module i2c_master_model #(parameter int HALF = 200) (
	// Bus lines; the data line is only ever pulled low
	output logic scl_o,
	output logic sda_low_o,
	input wire logic sda_i
);
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic start_cond();
		#(HALF / 4) sda_low_o = 1'b0;
		#(HALF) scl_o = 1'b1;
		#(HALF) sda_low_o = 1'b1;
		#(HALF) scl_o = 1'b0;
	endtask : start_cond
	// Clock is left high after stop, so it stands still between frames
	task automatic stop_cond();
		#(HALF / 4) sda_low_o = 1'b1;
		#(HALF) scl_o = 1'b1;
		#(HALF) sda_low_o = 1'b0;
		#(HALF);
	endtask : stop_cond
	task automatic bit_xfer(input logic b, output logic r);
		#(HALF / 4) sda_low_o = !b;
		#(HALF) scl_o = 1'b1;
		#(HALF / 2) r = sda_i;
		#(HALF / 2) scl_o = 1'b0;
	endtask : bit_xfer
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(d[i], r);
		end
		bit_xfer(1'b1, r);
		ack = !r;
	endtask : put_byte
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, r);
			d[i] = r;
		end
		bit_xfer(last, r);
	endtask : get_byte
endmodule : i2c_master_model

// File: bench/sensor_i2c_slave_port_tb.sv
// Self-checking bench of the sensor two-wire slave port
`timescale 1ns/1ps
module sensor_i2c_slave_port_tb;
	import sensor_i2c_pkg::*;
	localparam logic [2:0] TOP = 3'h5;
	logic clk_i = 1'b0;
	logic link_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [1:0] strap_lo = 2'h0;
	logic [1:0] strap_hi = 2'h0;
	logic [CUR_W-1:0] adc_sample = 9'h000;
	logic adc_valid = 1'b0;
	logic over_current = 1'b0;
	logic freeze = 1'b0;
	logic scl;
	logic m_low;
	logic sda_o;
	logic sda_oe_o;
	logic [1:0] range_sel_o;
	logic [3:0] fault_level_o;
	logic [7:0] avg_sel_o;
	logic [6:0] dev_addr;
	int fails = 0;
	int checks_done = 0;
	// Pull-up on the data line
	wire sda_bus = !(m_low || sda_oe_o);
	initial begin
		forever #5 clk_i = !clk_i;
	end
	initial begin
		#3.7;
		forever #7.5 link_clk_i = !link_clk_i;
	end
	sensor_i2c_slave_port #(.OWN_ADDR_MSB(TOP)) i_dut (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.link_clk_i(link_clk_i),
		.scl_i(scl),
		.sda_i(sda_bus),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe_o),
		.addr_strap_low_i(strap_lo),
		.addr_strap_high_i(strap_hi),
		.adc_sample_i(adc_sample),
		.adc_valid_i(adc_valid),
		.over_current_i(over_current),
		.freeze_i(freeze),
		.range_sel_o(range_sel_o),
		.fault_level_o(fault_level_o),
		.avg_sel_o(avg_sel_o)
	);
	i2c_master_model i_master (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda_bus));
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// Held long enough for the link domain to see it too
	task automatic do_reset();
		@(posedge clk_i) reset_n_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		repeat (20) @(posedge clk_i);
	endtask : do_reset
	task automatic bus_write(input logic [7:0] ra, input logic [47:0] d, input int n);
		logic ack;
		i_master.start_cond();
		i_master.put_byte({dev_addr, 1'b0}, ack);
		check({23'h0, ack}, 24'h1);
		i_master.put_byte(ra, ack);
		check({23'h0, ack}, 24'h1);
		for (int i = n - 1; i >= 0; i--) begin
			i_master.put_byte(d[8*i+:8], ack);
			check({23'h0, ack}, 24'h1);
		end
		i_master.stop_cond();
		repeat (30) @(posedge clk_i);
	endtask : bus_write
	task automatic bus_read(input logic [7:0] ra, input int n, output logic [47:0] d);
		logic ack;
		logic [7:0] b;
		i_master.start_cond();
		i_master.put_byte({dev_addr, 1'b0}, ack);
		i_master.put_byte(ra, ack);
		i_master.start_cond();
		i_master.put_byte({dev_addr, 1'b1}, ack);
		check({23'h0, ack}, 24'h1);
		for (int i = n - 1; i >= 0; i--) begin
			i_master.get_byte(i == 0, b);
			d[8*i+:8] = b;
		end
		i_master.stop_cond();
	endtask : bus_read
	task automatic t_straps();
		logic ack;
		for (int s = 0; s < 16; s++) begin
			@(posedge clk_i);
			strap_lo <= s[1:0];
			strap_hi <= s[3:2];
			do_reset();
			dev_addr = {TOP, s[3:0]};
			i_master.start_cond();
			i_master.put_byte({dev_addr ^ 7'h01, 1'b0}, ack);
			check({23'h0, ack}, 24'h0);
			i_master.start_cond();
			i_master.put_byte({dev_addr, 1'b0}, ack);
			check({23'h0, ack}, 24'h1);
			i_master.stop_cond();
		end
		$display("test straps done");
	endtask : t_straps
	task automatic t_read();
		logic [47:0] d;
		@(posedge clk_i);
		adc_sample <= 9'h1A5;
		adc_valid <= 1'b1;
		over_current <= 1'b1;
		@(posedge clk_i);
		adc_valid <= 1'b0;
		repeat (4) @(posedge clk_i);
		over_current <= 1'b0;
		repeat (50) @(posedge clk_i);
		bus_read(REG_DATA, 6, d);
		check(d[47:24], 24'h0007A5);
		check(d[23:0], 24'h000000);
		bus_read(REG_DATA, 3, d);
		check(d[23:0], 24'h0005A5);
		bus_write(REG_DATA, 48'h000400, 3);
		bus_read(REG_DATA, 3, d);
		check(d[23:0], 24'h0001A5);
		$display("test read done");
	endtask : t_read
	task automatic t_write_ctrl();
		logic [47:0] d;
		bus_write(REG_DATA, 48'h000000_0015A7, 6);
		check({10'h0, avg_sel_o, fault_level_o, range_sel_o}, 24'h0015A7);
		bus_read(REG_CTRL, 3, d);
		check(d[23:0], 24'h0015A7);
		$display("test write done");
	endtask : t_write_ctrl
	task automatic t_partial();
		logic ack;
		logic r;
		bus_write(REG_CTRL, 48'h00FFFF, 2);
		check({10'h0, avg_sel_o, fault_level_o, range_sel_o}, 24'h0015A7);
		i_master.start_cond();
		i_master.put_byte({dev_addr, 1'b0}, ack);
		i_master.put_byte(REG_CTRL, ack);
		i_master.put_byte(8'h00, ack);
		i_master.put_byte(8'h00, ack);
		for (int i = 0; i < 3; i++) begin
			i_master.bit_xfer(1'b0, r);
		end
		i_master.stop_cond();
		repeat (30) @(posedge clk_i);
		check({10'h0, avg_sel_o, fault_level_o, range_sel_o}, 24'h0015A7);
		bus_write(REG_CTRL, 48'h000001, 3);
		check({10'h0, avg_sel_o, fault_level_o, range_sel_o}, 24'h000001);
		$display("test partial done");
	endtask : t_partial
	task automatic put_sample(input logic [CUR_W-1:0] v);
		@(posedge clk_i);
		adc_sample <= v;
		adc_valid <= 1'b1;
		@(posedge clk_i);
		adc_valid <= 1'b0;
	endtask : put_sample
	// Frozen result must survive a sample, then a two-sample window is averaged
	task automatic t_freeze_avg();
		logic [47:0] d;
		@(posedge clk_i);
		freeze <= 1'b1;
		repeat (4) @(posedge clk_i);
		put_sample(9'h0AA);
		repeat (50) @(posedge clk_i);
		bus_read(REG_DATA, 3, d);
		check(d[23:0], 24'h0001A5);
		@(posedge clk_i);
		freeze <= 1'b0;
		bus_write(REG_CTRL, 48'h000040, 3);
		check({10'h0, avg_sel_o, fault_level_o, range_sel_o}, 24'h000040);
		put_sample(9'h010);
		put_sample(9'h031);
		repeat (50) @(posedge clk_i);
		bus_read(REG_DATA, 3, d);
		check(d[23:0], 24'h000220);
		$display("test freeze and averaging done");
	endtask : t_freeze_avg
	initial begin
		repeat (90000) @(posedge clk_i);
		fails++;
		tally_and_finish();
	end
	initial begin
		t_straps();
		t_read();
		t_write_ctrl();
		t_partial();
		t_freeze_avg();
		tally_and_finish();
	end
endmodule : sensor_i2c_slave_port_tb
